// *** sst_safety_self_test_unit.sv ***
// Behaviour
// - monitors are exercised periodically at run time without any command
// - a five-bit slot tag is programmable for every slot of both channels
// - sensor data reads return the slot's programmed tag alongside the data
// - returned frame carries a global fault: supply undervoltage or parity fault
// - clock errors stay out of global fault; reset at once when reaction bit is 0
// - tag and decoded payload are stored in one write, slot from dec_slot
// - checksum and tag mismatch failures forceable only in self test mode
// - after each valid read the buffer must hold the empty code 1F0
// - failed empty check latches per-channel fault, cleared on status read
// - setup bit 0 keeps old data after a read to provoke the fault
// - selected output in test mode is driven static by test level bit 10
// - select field 9:5: 10101 output one, 10110 output two, else off
// - never more than one data output in test mode
// - coupling check starts only with both interfaces off, else results reset
// - while checking, channel-on and supply-disable commands are ignored
// - only abort stops a running check; master-mode abort sets abort flag
// - busy only while a check runs; done set when it finishes
// - done, abort and all results clear on read or a start request while idle
// - status bits 0 and 8 hold master ground-short results until cleared
// - slave mode pulls both lines down for 512 us, then releases each
// - slave mode passes a channel only if its undervoltage flag is one
// - master check ends after its schedule; slave abort sets no abort flag
`timescale 1ns/1ps
module sst_safety_self_test_unit
   import sst_pkg::*;
#(
   parameter int CH_SLOTS      = 4,
   parameter int SETTLE_CYCLES = sst_pkg::SETTLE_CYCLES_DEF,
   parameter int DISCH_CYCLES  = sst_pkg::DISCH_CYCLES_DEF,
   parameter int MON_PERIOD    = sst_pkg::MON_PERIOD_DEF
) (
   // clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   // analog comparator and status pins
   input  wire logic [1:0]                    line_undervoltage,
   input  wire logic [1:0]                    battery_short_raw,
   input  wire logic [1:0]                    ground_short_raw,
   input  wire logic [1:0]                    interface_on,
   input  wire logic                          monitor_response,
   output logic                               monitor_test_inject,
   output logic                               monitor_check_fault,
   // fault sources for the global fault bit and clock reaction
   input  wire logic                          supply_undervoltage,
   input  wire logic                          parity_fault,
   input  wire logic                          clock_error,
   input  wire logic                          clock_fault_reaction,
   output logic                               clock_reset_request,
   // slot tag programming
   input  wire logic                          tag_write,
   input  wire logic [$clog2(2*CH_SLOTS)-1:0] tag_slot,
   input  wire logic [sst_pkg::TAG_W-1:0]     tag_value,
   // decoder side
   input  wire logic                          dec_valid,
   input  wire logic [$clog2(2*CH_SLOTS)-1:0] dec_slot,
   input  wire logic [sst_pkg::PAY_W-1:0]     dec_payload,
   // sensor data read
   input  wire logic                          rd_req,
   input  wire logic [$clog2(2*CH_SLOTS)-1:0] rd_slot,
   output sst_pkg::sst_slot_word_type         rd_word,
   output logic                               rd_crc_fail,
   // self test mode and setup
   input  wire logic                          self_test_enter,
   input  wire logic                          self_test_exit,
   output logic                               self_test_mode,
   input  wire logic [sst_pkg::SELF_TEST_SETUP_REGISTER_W-1:0]    self_test_setup_register,
   input  wire logic [sst_pkg::STS_W-1:0]     self_test_settings,
   // data outputs
   input  wire logic                          data_in_one,
   input  wire logic                          data_in_two,
   output logic                               data_output_one,
   output logic                               data_output_two,
   // channel coupling check
   input  wire logic                          cc_start,
   input  wire logic                          cc_master,
   input  wire logic                          cc_abort,
   input  wire logic                          cc_results_read,
   output logic                               coupling_busy_flag,
   output logic                               coupling_done_flag,
   output logic                               coupling_abort_flag,
   output logic [1:0]                         coupling_result_flag,
   output logic [1:0]                         coupling_ground_short_result,
   output logic [1:0]                         cc_battery_short_result,
   output logic [1:0]                         cc_channel_enable,
   output logic [1:0]                         pulldown_test_current,
   // channel and supply commands
   input  wire logic [1:0]                    channel_on_cmd,
   input  wire logic                          supply_off_cmd,
   output logic [1:0]                         channel_on_accept,
   output logic                               supply_off_accept,
   // second status word
   input  wire logic                          sr2_read,
   output logic [sst_pkg::SR2_W-1:0]          second_status_register
);
   localparam int SLOTS = 2 * CH_SLOTS;
   localparam int SW    = $clog2(SLOTS);

   sst_slot_word_type slot_mem [SLOTS];
   logic [TAG_W-1:0]  slot_tag [SLOTS];
   logic [1:0]        uv;
   logic [1:0]        stb;
   logic [1:0]        gs_rt;
   logic [1:0]        if_on;
   logic              mon_resp;
   logic              chk_pend;
   logic [SW-1:0]     chk_slot;
   logic [1:0]        empty_buffer_fault;
   logic [MON_W-1:0]  mon_cnt;
   logic              ot_one;
   logic              ot_two;
   sst_cc_state_type  cc_state;
   logic [TMR_W-1:0]  cc_tmr;
   logic              cc_ch;
   logic              cc_is_master;
   logic [1:0]        cc_excl;
   logic              gs_hold;
   logic              cc_clear;
   logic              tmr_end;

   // slot index to physical channel
   function automatic logic slot_chan(input logic [SW-1:0] s);
      return (32'(s) >= CH_SLOTS);
   endfunction : slot_chan

   // one-hot test select decode
   function automatic logic [1:0] ot_decode(input logic [4:0] sel);
      return {sel == OT_SEL_TWO, sel == OT_SEL_ONE};
   endfunction : ot_decode

   // pin-side inputs come from the analog domain
   sst_sync3 #(.WIDTH(9)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in ({monitor_response, interface_on, ground_short_raw, battery_short_raw, line_undervoltage}),
      .sync_out ({mon_resp, if_on, gs_rt, stb, uv})
   );

   // periodic monitor exercise; a stuck comparator shows as a missing response
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mon_cnt             <= '0;
         monitor_test_inject <= 1'b0;
         monitor_check_fault <= 1'b0;
      end else begin
         mon_cnt <= (32'(mon_cnt) >= MON_PERIOD - 1) ? '0 : mon_cnt + 1'b1;
         monitor_test_inject <= (32'(mon_cnt) < MON_WINDOW);
         if (32'(mon_cnt) == MON_WINDOW - 1 && !mon_resp) begin
            monitor_check_fault <= 1'b1;
         end
      end
   end

   // clock error bypasses the global fault and requests reset directly when the reaction bit is 0
   assign clock_reset_request = clock_error && !clock_fault_reaction;

   // self test mode entered and left by command
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         self_test_mode <= 1'b0;
      end else if (self_test_enter) begin
         self_test_mode <= 1'b1;
      end else if (self_test_exit) begin
         self_test_mode <= 1'b0;
      end
   end

   // tag table programmed by the host
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SLOTS; i++) slot_tag[i] <= '0;
      end else if (tag_write) begin
         slot_tag[tag_slot] <= tag_value;
      end
   end

   // data store: decoder writes tag, fault and payload in one access;
   // a read refills with the empty code unless the buffer test holds it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SLOTS; i++) slot_mem[i] <= '{1'b0, '0, EMPTY_CODE};
      end else begin
         if (rd_req && !self_test_setup_register[SELF_TEST_SETUP_REGISTER_BUF_TEST]) begin
            slot_mem[rd_slot].payload <= EMPTY_CODE;
         end
         if (dec_valid) begin
            slot_mem[dec_slot] <= '{supply_undervoltage || parity_fault, slot_tag[dec_slot], dec_payload};
         end
      end
   end

   // read answer registered; forced failures only inside self test mode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_word     <= '0;
         rd_crc_fail <= 1'b0;
      end else if (rd_req) begin
         rd_word <= slot_mem[rd_slot];
         rd_word.gfault <= slot_mem[rd_slot].gfault || supply_undervoltage || parity_fault;
         rd_word.tag <= slot_mem[rd_slot].tag
                        ^ TAG_W'(self_test_mode && self_test_setup_register[SELF_TEST_SETUP_REGISTER_FORCE_TAG]);
         rd_crc_fail <= self_test_mode && self_test_setup_register[SELF_TEST_SETUP_REGISTER_FORCE_CRC];
      end
   end

   // empty check one cycle after the read; a new decoder word in that
   // cycle is legitimate data, so it masks the check
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_pend           <= 1'b0;
         chk_slot           <= '0;
         empty_buffer_fault <= '0;
      end else begin
         chk_pend <= rd_req && !(dec_valid && dec_slot == rd_slot);
         chk_slot <= rd_slot;
         if (sr2_read) begin
            empty_buffer_fault <= '0;
         end
         if (chk_pend && slot_mem[chk_slot].payload != EMPTY_CODE
             && !(dec_valid && dec_slot == chk_slot)) begin
            empty_buffer_fault[slot_chan(chk_slot)] <= 1'b1;
         end
      end
   end

   // output test select, at most one output at a time by decode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ot_one <= 1'b0;
         ot_two <= 1'b0;
      end else begin
         {ot_two, ot_one} <= ot_decode(self_test_settings[OT_SEL_HI:OT_SEL_LO]);
      end
   end

   // data outputs registered; test level overrides only the selected one
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_output_one <= 1'b0;
         data_output_two <= 1'b0;
      end else begin
         data_output_one <= ot_one ? self_test_settings[OT_LEVEL_BIT] : data_in_one;
         data_output_two <= ot_two ? self_test_settings[OT_LEVEL_BIT] : data_in_two;
      end
   end

   assign tmr_end  = (32'(cc_tmr) == 0);
   assign cc_clear = cc_results_read || (cc_start && cc_state == CC_IDLE);

   // coupling check sequencer; the timer is loaded on every entry to a state other than CC_IDLE
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cc_state     <= CC_IDLE;
         cc_tmr       <= '0;
         cc_ch        <= 1'b0;
         cc_is_master <= 1'b0;
         cc_excl      <= '0;
      end else begin
         cc_tmr <= tmr_end ? '0 : cc_tmr - 1'b1;
         unique case (cc_state)
            CC_IDLE: begin
               if (cc_start && if_on == 2'b00) begin
                  cc_is_master <= cc_master;
                  cc_ch        <= 1'b0;
                  cc_excl      <= '0;
                  cc_tmr       <= TMR_W'(SETTLE_CYCLES - 1);
                  cc_state     <= cc_master ? CC_STB_ON : CC_SLV;
               end
            end
            CC_SLV: begin
               if (tmr_end) cc_state <= CC_IDLE;
            end
            CC_STB_ON: begin
               if (tmr_end) begin
                  if (stb[cc_ch]) cc_excl[cc_ch] <= 1'b1;
                  cc_tmr   <= TMR_W'(DISCH_CYCLES - 1);
                  cc_state <= CC_STB_DIS;
               end
            end
            CC_STB_DIS: begin
               if (tmr_end) begin
                  cc_tmr <= TMR_W'(SETTLE_CYCLES - 1);
                  if (!cc_ch) begin
                     cc_ch    <= 1'b1;
                     cc_state <= CC_STB_ON;
                  end else if (!cc_excl[0]) begin
                     cc_ch    <= 1'b0;
                     cc_state <= CC_X_ON;
                  end else if (!cc_excl[1]) begin
                     cc_state <= CC_X_ON;
                  end else begin
                     cc_state <= CC_IDLE;
                  end
               end
            end
            CC_X_ON: begin
               if (tmr_end) begin
                  cc_tmr   <= TMR_W'(DISCH_CYCLES - 1);
                  cc_state <= CC_X_DIS;
               end
            end
            CC_X_DIS: begin
               if (tmr_end) begin
                  if (!cc_ch && !cc_excl[1]) begin
                     cc_ch    <= 1'b1;
                     cc_tmr   <= TMR_W'(SETTLE_CYCLES - 1);
                     cc_state <= CC_X_ON;
                  end else begin
                     cc_state <= CC_IDLE;
                  end
               end
            end
         endcase
         if (cc_abort && cc_state != CC_IDLE) begin
            cc_state <= CC_IDLE;
         end
      end
   end

   // result flags; a completing check wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         coupling_done_flag           <= 1'b0;
         coupling_abort_flag          <= 1'b0;
         coupling_result_flag         <= '0;
         coupling_ground_short_result <= '0;
         cc_battery_short_result      <= '0;
         gs_hold                      <= 1'b0;
      end else begin
         if (cc_clear) begin
            coupling_done_flag           <= 1'b0;
            coupling_abort_flag          <= 1'b0;
            coupling_result_flag         <= '0;
            coupling_ground_short_result <= '0;
            cc_battery_short_result      <= '0;
            gs_hold                      <= 1'b0;
         end
         if (cc_state == CC_SLV && tmr_end && !cc_abort) begin
            coupling_result_flag <= ~uv;
            coupling_done_flag   <= 1'b1;
         end
         if (cc_state == CC_STB_ON && tmr_end && stb[cc_ch] && !cc_abort) begin
            cc_battery_short_result[cc_ch] <= 1'b1;
         end
         if (cc_state == CC_X_ON && tmr_end && !cc_abort) begin
            if (uv[cc_ch]) coupling_ground_short_result[cc_ch] <= 1'b1;
            if (!uv[!cc_ch]) coupling_result_flag[!cc_ch] <= 1'b1;
         end
         if (cc_is_master && !cc_abort && tmr_end
             && ((cc_state == CC_X_DIS && !(!cc_ch && !cc_excl[1]))
                 || (cc_state == CC_STB_DIS && cc_ch && cc_excl == 2'b11))) begin
            coupling_done_flag <= 1'b1;
            gs_hold            <= 1'b1;
         end
         if (cc_abort && cc_is_master && cc_state != CC_IDLE) begin
            coupling_abort_flag <= 1'b1;
         end
      end
   end

   // line drive derived from the sequencer state
   always_comb begin
      coupling_busy_flag    = (cc_state != CC_IDLE);
      cc_channel_enable     = '0;
      pulldown_test_current = '0;
      if (cc_state == CC_SLV) pulldown_test_current = 2'b11;
      if (cc_state == CC_STB_ON || cc_state == CC_X_ON) cc_channel_enable[cc_ch] = 1'b1;
      if (cc_state == CC_STB_DIS || cc_state == CC_X_DIS) pulldown_test_current[cc_ch] = 1'b1;
   end

   // commands that would disturb the lines are dropped while checking
   assign channel_on_accept = coupling_busy_flag ? 2'b00 : channel_on_cmd;
   assign supply_off_accept = supply_off_cmd && !coupling_busy_flag;

   // second status word; ground-short bits switch to held results
   always_comb begin
      second_status_register           = '0;
      second_status_register[SR2_GS1]  = gs_hold ? coupling_ground_short_result[0] : gs_rt[0];
      second_status_register[SR2_GS2]  = gs_hold ? coupling_ground_short_result[1] : gs_rt[1];
      second_status_register[SR2_BE1]  = empty_buffer_fault[0];
      second_status_register[SR2_BE2]  = empty_buffer_fault[1];
      second_status_register[SR2_STB1] = cc_battery_short_result[0];
      second_status_register[SR2_STB2] = cc_battery_short_result[1];
   end
endmodule : sst_safety_self_test_unit

// *** sst_pkg.sv ***
package sst_pkg;
   // clock and timing
   localparam int CLK_MHZ           = 100;
   localparam int SETTLE_US         = 512;  // pull-down / settle window
   localparam int DISCH_US          = 128;  // master-mode discharge window
   localparam int SETTLE_CYCLES_DEF = SETTLE_US * CLK_MHZ;
   localparam int DISCH_CYCLES_DEF  = DISCH_US * CLK_MHZ;
   localparam int TMR_W             = 17;
   // data words
   localparam int TAG_W             = 5;
   localparam int PAY_W             = 16;
   localparam logic [PAY_W-1:0] EMPTY_CODE = 16'h01f0;
   // output test field in the self-test settings word
   localparam int STS_W             = 11;
   localparam int OT_LEVEL_BIT      = 10;
   localparam int OT_SEL_HI         = 9;
   localparam int OT_SEL_LO         = 5;
   localparam logic [4:0] OT_SEL_ONE = 5'h15;
   localparam logic [4:0] OT_SEL_TWO = 5'h16;
   // self-test setup word
   localparam int SELF_TEST_SETUP_REGISTER_W            = 3;
   localparam int SELF_TEST_SETUP_REGISTER_BUF_TEST     = 0;
   localparam int SELF_TEST_SETUP_REGISTER_FORCE_CRC    = 1;
   localparam int SELF_TEST_SETUP_REGISTER_FORCE_TAG    = 2;
   // second status word layout
   localparam int SR2_W             = 16;
   localparam int SR2_GS1           = 0;
   localparam int SR2_GS2           = 8;
   localparam int SR2_BE1           = 1;
   localparam int SR2_BE2           = 9;
   localparam int SR2_STB1          = 2;
   localparam int SR2_STB2          = 10;
   // monitor self check
   localparam int MON_PERIOD_DEF    = 1000;
   localparam int MON_WINDOW        = 16;
   localparam int MON_W             = 16;

   // one slot entry: tag, global fault and payload written together
   typedef struct packed {
      logic             gfault;
      logic [TAG_W-1:0] tag;
      logic [PAY_W-1:0] payload;
   } sst_slot_word_type;

   typedef enum logic [5:0] {
      CC_IDLE    = 6'b000001,
      CC_SLV     = 6'b000010,
      CC_STB_ON  = 6'b000100,
      CC_STB_DIS = 6'b001000,
      CC_X_ON    = 6'b010000,
      CC_X_DIS   = 6'b100000
   } sst_cc_state_type;
endpackage : sst_pkg

// *** sst_sync3.sv ***
`timescale 1ns/1ps
module sst_sync3 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // asynchronous in, filtered out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // three stages; a bit only moves once stages two and three agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               sync_out[i] <= stage3[i];
            end
         end
      end
   end
endmodule : sst_sync3

// *** sst_line_model.sv ***
`timescale 1ns/1ps
module sst_line_model (
   // from the unit
   input  wire logic [1:0] cc_channel_enable,
   input  wire logic       monitor_test_inject,
   // fault injected by the bench
   input  wire logic [1:0] line_fault,
   // to the unit
   output logic      [1:0] line_undervoltage,
   output logic            monitor_response
);
   // an unpowered line sags to undervoltage; a fault inverts that
   assign line_undervoltage = ~cc_channel_enable ^ line_fault;
   assign monitor_response  = monitor_test_inject; // healthy monitor follows stimulus
endmodule : sst_line_model

// *** sst_safety_self_test_unit_chk.sv ***
`timescale 1ns/1ps
module sst_chk (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // inputs of the unit
   input wire logic        clock_error,
   input wire logic        clock_fault_reaction,
   input wire logic [10:0] self_test_settings,
   input wire logic        cc_start,
   input wire logic        cc_abort,
   input wire logic [1:0]  channel_on_cmd,
   // outputs of the unit
   input wire logic        clock_reset_request,
   input wire logic        data_output_one,
   input wire logic        data_output_two,
   input wire logic        coupling_busy_flag,
   input wire logic        coupling_done_flag,
   input wire logic        coupling_abort_flag,
   input wire logic [1:0]  coupling_result_flag,
   input wire logic [1:0]  pulldown_test_current,
   input wire logic [1:0]  channel_on_accept,
   input wire logic        monitor_test_inject
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // slave window of 8 cycles matches the bench build, not the full count
   AST_CLK_RST: assert property (clock_reset_request == (clock_error && !clock_fault_reaction))
      else $error("clock reset request wrong");
   AST_OUT_HIGH: assert property (
      (self_test_settings[9:5] == 5'h15 && self_test_settings[10])[*3] |-> data_output_one)
      else $error("output one not high");
   AST_OUT_LOW: assert property (
      (self_test_settings[9:5] == 5'h16 && !self_test_settings[10])[*3] |-> !data_output_two)
      else $error("output two not low");
   AST_SLV_END: assert property (
      $rose(coupling_busy_flag) && pulldown_test_current == 2'b11 && !cc_abort ##1 (!cc_abort)[*7]
      |=> !coupling_busy_flag && coupling_done_flag) else $error("slave check length");
   AST_ABORT: assert property (coupling_busy_flag && cc_abort |=> !coupling_busy_flag &&
      coupling_abort_flag == ($past(pulldown_test_current) != 2'b11)) else $error("abort handling");
   AST_START_CLR: assert property (cc_start && !coupling_busy_flag |=>
      !coupling_done_flag && !coupling_abort_flag && coupling_result_flag == 2'b00) else $error("start clear");
   AST_GATE: assert property (channel_on_accept == (coupling_busy_flag ? 2'b00 : channel_on_cmd))
      else $error("channel on gating");
   AST_MON: assert property ($rose(monitor_test_inject) |-> ##15 monitor_test_inject ##1 !monitor_test_inject)
      else $error("monitor stimulus window");
endmodule : sst_chk

bind sst_safety_self_test_unit sst_chk u_chk (.*);

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("mismatch %0t %h %h", $time, g, e); end end
module testbench;
   import sst_pkg::*;
   // unit and model nets
   logic              core_clk = 1'b0;
   logic              rst_n, tag_write, dec_valid, rd_req, self_test_enter, self_test_exit, supply_undervoltage;
   logic              parity_fault, clock_error, clock_fault_reaction, data_in_one, data_in_two, cc_start;
   logic              cc_master, cc_abort, cc_results_read, supply_off_cmd, sr2_read, monitor_response;
   logic              monitor_test_inject, monitor_check_fault, clock_reset_request, rd_crc_fail, self_test_mode;
   logic              data_output_one, data_output_two, coupling_busy_flag, coupling_done_flag;
   logic              coupling_abort_flag, supply_off_accept;
   logic [1:0]        line_undervoltage, battery_short_raw, ground_short_raw, interface_on, line_fault;
   logic [1:0]        channel_on_cmd, coupling_result_flag, coupling_ground_short_result;
   logic [1:0]        cc_battery_short_result, cc_channel_enable, pulldown_test_current, channel_on_accept;
   logic [2:0]        tag_slot, dec_slot, rd_slot, self_test_setup_register;
   logic [4:0]        tag_value, sel, tags [8];
   logic [10:0]       self_test_settings;
   logic [15:0]       dec_payload, second_status_register;
   sst_slot_word_type rd_word;
   int                miscompares = 0, n_tests = 0;

   // short counts keep coupling runs brief
   sst_safety_self_test_unit #(.SETTLE_CYCLES(8), .DISCH_CYCLES(4), .MON_PERIOD(40)) uut (.*);
   sst_line_model u_line (.*);

   always #5 core_clk = ~core_clk;

   task automatic tick(input int n = 1);
      repeat (n) @(negedge core_clk);
   endtask : tick
   // strobe for exactly one rising edge
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
   endtask : pulse
   task automatic rd(input int s);
      rd_slot = 3'(s);
      pulse(rd_req);
      tick();
   endtask : rd
   task automatic cc_run(input logic m);
      cc_master = m;
      pulse(cc_start);
      `CHK({channel_on_accept, supply_off_accept}, 3'b000)
      `CHK(pulldown_test_current, m ? 2'b00 : 2'b11)
      for (int i = 0; i < 200 && coupling_busy_flag; i++) tick();
      `CHK(coupling_done_flag, 1'b1)
   endtask : cc_run
   function automatic logic exp_out(logic [10:0] sts, logic [4:0] code, logic din);
      return (sts[9:5] == code) ? sts[10] : din;
   endfunction : exp_out
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   // watchdog: the sequence needs under 1000 cycles
   initial begin
      #100000;
      miscompares++;
      end_of_test();
   end

   initial begin
      {rst_n, tag_write, dec_valid, rd_req, self_test_enter, self_test_exit, supply_undervoltage, parity_fault} = '0;
      {clock_error, clock_fault_reaction, data_in_one, data_in_two, cc_start, cc_master, cc_abort} = '0;
      {cc_results_read, sr2_read, battery_short_raw, ground_short_raw, interface_on} = '0;
      {line_fault, tag_slot, dec_slot, rd_slot, self_test_setup_register, tag_value, sel} = '0;
      {self_test_settings, dec_payload} = '0;
      {channel_on_cmd, supply_off_cmd} = 3'b111;
      void'($urandom(66487));
      tick(16);
      rst_n = 1'b1;
      // upper slots run in self test mode, so forcing applies only there
      self_test_setup_register = 3'b110;
      for (int s = 0; s < 8; s++) begin
         if (s == 4) pulse(self_test_enter);
         tags[s] = 5'($urandom);
         tag_slot = 3'(s);
         tag_value = tags[s];
         pulse(tag_write);
         dec_slot = 3'(s);
         dec_payload = 16'($urandom);
         {supply_undervoltage, parity_fault} = 2'($urandom);
         pulse(dec_valid);
         rd(s);
         `CHK(rd_word, {supply_undervoltage | parity_fault, tags[s] ^ 5'(s > 3), dec_payload})
         `CHK(rd_crc_fail, s > 3)
         rd(s);
         `CHK(rd_word.payload, EMPTY_CODE)
      end
      // stale data left behind must latch the channel one fault only
      self_test_setup_register = 3'b001;
      dec_slot = 3'd2;
      pulse(dec_valid);
      rd(2);
      rd(2);
      `CHK(rd_word.payload, dec_payload)
      tick(4);
      `CHK({second_status_register[9], second_status_register[1]}, 2'b01)
      self_test_setup_register = 3'b000;
      pulse(sr2_read);
      `CHK(second_status_register[1], 1'b0)
      $display("test data done");
      for (int i = 0; i < 9; i++) begin
         sel = (i % 3 == 0) ? 5'h15 : (i % 3 == 1) ? 5'h16 : 5'($urandom);
         self_test_settings = {1'($urandom), sel, 5'($urandom)};
         {data_in_one, data_in_two} = 2'($urandom);
         tick(3);
         `CHK(data_output_one, exp_out(self_test_settings, OT_SEL_ONE, data_in_one))
         `CHK(data_output_two, exp_out(self_test_settings, OT_SEL_TWO, data_in_two))
      end
      `CHK(monitor_check_fault, 1'b0)
      $display("test outputs done");
      interface_on = 2'b01;
      tick(6);
      pulse(cc_start);
      `CHK(coupling_busy_flag, 1'b0)
      interface_on = 2'b00;
      line_fault = 2'b01;
      tick(6);
      cc_run(1'b0);
      `CHK(coupling_result_flag, 2'b01)
      pulse(cc_results_read);
      `CHK({coupling_done_flag, coupling_result_flag}, 3'b000)
      cc_run(1'b1);
      `CHK({coupling_ground_short_result, coupling_result_flag}, 4'b0101)
      `CHK({second_status_register[8], second_status_register[0]}, 2'b01)
      rst_n = 1'b0;
      tick();
      `CHK({coupling_done_flag, coupling_ground_short_result, second_status_register[0]}, 4'b0000)
      rst_n = 1'b1;
      tick(6);
      for (int m = 1; m >= 0; m--) begin
         cc_master = m[0];
         pulse(cc_start);
         tick(3);
         pulse(cc_abort);
         `CHK({coupling_busy_flag, coupling_abort_flag}, {1'b0, m[0]})
      end
      $display("test coupling done");
      end_of_test();
   end
endmodule : testbench
